// File: rl_port_rate_limiter.sv
// Behaviour
// - below 1 Mbps, 64k/640k bps steps
// - above 1 Mbps, 1M/10M bps steps
// - fine pps steps 64 then 128, gig x10
// - code zero means full line rate
// - codes 1-100 scale by 1 Mbps/1.92 kpps
// - codes 101-115 select fine limits
// - egress pps also bounded by bps code
// - ingress and egress settings independent per port
// - 10 Mbps port ignores limits above 10M
// - meter per priority and per queue
// - frame bits DA-FCS plus optional IFG/preamble
// - two-bit selector picks counted frame types
// - over limit drops, or pauses if enabled
// - priority from port, 802.1p or DiffServ remap
// - four codes in 4Q, two in 2Q
// - leaky bucket stretches egress frame gap
// - exhausted memory triggers drop or pause
// - top queue exact, lower by ratio
// - highest queue never ratio limited
`timescale 1ns/1ps
`include "rl_map.svh"

module rl_port_rate_limiter #(
  parameter int NP       = 5,
  parameter int TICK_CYC = `RL_TICK_NS / `RL_CLK_NS
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [2*NP-1:0]     portSpeed,
  input  wire logic [NP-1:0]       memFull,
  input  wire rl_pkg::rl_inframe_t inFrame,
  output      logic                inDone,
  output      logic                inDrop,
  output      logic [NP-1:0]       inPause,
  input  wire rl_pkg::rl_egframe_t egSent,
  output      logic [4*NP-1:0]     egReady,
  output      logic [NP-1:0]       congDrop,
  output      logic [NP-1:0]       congPause
);

  localparam int TW = $clog2(TICK_CYC + 1);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // refill per tick for a code, in bits or milli-packets
  function automatic logic [31:0] rlRate(input logic [6:0] c, input logic [1:0] spd, input logic pps);
    logic [31:0] v;
    v = `RL_UNL;
    if (c == 7'h00) begin
      v = `RL_UNL;
    end else if (c <= `RL_CODE_CRS) begin
      if (spd == rl_pkg::RL_SPD_10 && c > `RL_CAP_10M) begin
        v = `RL_UNL;
      end else begin
        v = pps ? 32'(c) * `RL_STEP_PPS : 32'(c) * `RL_STEP_BPS;
      end
    end else if (c <= `RL_CODE_F1) begin
      if (pps) begin
        v = (c == `RL_CODE_F0) ? `RL_FIRST_PPS : 32'(c - `RL_CODE_F0) * `RL_FINE_PPS;
      end else begin
        v = (c == `RL_CODE_F1) ? `RL_LAST_BPS : 32'(c - `RL_CODE_CRS) * `RL_FINE_BPS;
      end
    end else begin
      v = `RL_UNL;
    end
    if (spd == rl_pkg::RL_SPD_1000 && v != `RL_UNL) begin
      v = v * `RL_GIG_MUL;
    end
    return v;
  endfunction : rlRate

  // bps code that bounds an egress pps code
  function automatic logic [6:0] rlBound(input logic [6:0] c);
    logic [6:0] b;
    b = c;
    case (c)
      7'h01:   b = 7'h03;
      7'h02:   b = 7'h06;
      7'h65:   b = 7'h66;
      7'h66:   b = 7'h68;
      7'h67:   b = 7'h6c;
      7'h68:   b = 7'h70;
      7'h69, 7'h6a, 7'h6b: b = 7'h01;
      7'h6c, 7'h6d, 7'h6e, 7'h6f, 7'h70: b = 7'h02;
      7'h71, 7'h72, 7'h73: b = 7'h03;
      default: b = (c >= 7'h03 && c <= `RL_CAP_10M) ? `RL_CAP_10M : c;
    endcase
    return b;
  endfunction : rlBound

  // leaky bucket step: refill on tick, cap, then charge
  function automatic logic signed [33:0] rlNext(input logic signed [33:0] c, input logic [31:0] r,
                                                input logic t, input logic g, input logic [31:0] k,
                                                input logic [31:0] burst);
    logic signed [33:0] n;
    logic signed [33:0] lim;
    n   = c;
    lim = $signed({2'b00, r}) + $signed({2'b00, burst});
    if (r == `RL_UNL) begin
      n = '0;
    end else begin
      if (t) n = n + $signed({2'b00, r});
      if (n > lim) n = lim;
      if (g) n = n - $signed({2'b00, k});
    end
    return n;
  endfunction : rlNext

  // lower queues take a share of the top queue rate
  function automatic logic [31:0] rlScale(input logic [31:0] r, input logic [3:0] ratio);
    logic [31:0] p;
    p = r * 32'(ratio);
    return (r == `RL_UNL) ? `RL_UNL : (p >> `RL_RATIO_SH);
  endfunction : rlScale

  // highest active queue for a queue mode
  function automatic logic [1:0] rlTopQ(input logic qen, input logic [1:0] qm);
    return !qen ? 2'h0 : (qm == 2'h0) ? 2'h0 : (qm == 2'h1) ? 2'h1 : 2'h3;
  endfunction : rlTopQ

  // address decode, shared by read and write
  function automatic rl_pkg::rl_dec_t rlDecode(input logic [11:0] a);
    rl_pkg::rl_dec_t d;
    d.glb  = a < `RL_A_PORT0;
    d.idx  = a[4:2];
    d.port = 3'((a - `RL_A_PORT0) >> `RL_PORT_SH);
    if (d.glb) begin
      d.hit = a[11:5] == 7'h00 && d.idx <= `RL_G_DSCP3;
    end else begin
      d.hit = 32'(d.port) < NP && a[11:8] <= 4'(1 + ((NP - 1) >> 3)) && d.idx <= `RL_R_STAT
              && (a - `RL_A_PORT0) < 12'(NP << `RL_PORT_SH);
    end
    return d;
  endfunction : rlDecode

  // byte strobes to bit mask
  function automatic logic [31:0] rlMask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) m[8*i +: 8] = {8{s[i]}};
    return m;
  endfunction : rlMask

  // ----------------------------------------------------------------
  // registers and bus state
  // ----------------------------------------------------------------
  logic [31:0]     gCtrl;
  logic [31:0]     pcpMap;
  logic [31:0]     dscpMap [4];
  logic [31:0]     portCtl [NP];
  logic [31:0]     inCtl   [NP];
  logic [31:0]     inCode  [NP];
  logic [31:0]     egCode  [NP];
  logic [31:0]     ratio   [NP];
  logic [3:0]      inOk    [NP];
  logic [3:0]      egOk    [NP];
  logic [11:0]     awAddr;
  logic [31:0]     wData;
  logic [3:0]      wStrb;
  logic            awHeld;
  logic            wHeld;
  rl_pkg::rl_wst_t wSt;
  rl_pkg::rl_rst_t rSt;
  rl_pkg::rl_dec_t wDec;
  rl_pkg::rl_dec_t rDec;
  logic            doWrite;
  logic [31:0]     wMask;
  logic [31:0]     next_rdata;
  logic [TW-1:0]   tickCnt;
  logic            tick;
  logic            qen;

  assign qen = gCtrl[`RL_G_QEN];

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------

  // handshake outputs
  assign s_axi_awready = !awHeld && wSt == rl_pkg::RL_W_IDLE;
  assign s_axi_wready  = !wHeld && wSt == rl_pkg::RL_W_IDLE;
  assign s_axi_bvalid  = wSt == rl_pkg::RL_W_RESP;
  assign s_axi_arready = rSt == rl_pkg::RL_R_IDLE;
  assign s_axi_rvalid  = rSt == rl_pkg::RL_R_DATA;
  assign wDec          = rlDecode(awAddr);
  assign rDec          = rlDecode(s_axi_araddr);
  assign doWrite       = awHeld && wHeld && wSt == rl_pkg::RL_W_IDLE;
  assign wMask         = rlMask(wStrb);

  // write channel capture, in either order
  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld      <= 1'b0;
      wHeld       <= 1'b0;
      awAddr      <= '0;
      wData       <= '0;
      wStrb       <= '0;
      wSt         <= rl_pkg::RL_W_IDLE;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      case (wSt)
        rl_pkg::RL_W_IDLE: begin
          if (doWrite) begin
            wSt         <= rl_pkg::RL_W_RESP;
            s_axi_bresp <= wDec.hit ? 2'h0 : 2'h3; // decode error when unmapped
          end
        end
        rl_pkg::RL_W_RESP: begin
          if (s_axi_bready) begin
            wSt    <= rl_pkg::RL_W_IDLE;
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
          end
        end
        default: wSt <= rl_pkg::RL_W_IDLE;
      endcase
    end
  end

  // global register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      gCtrl  <= `RL_RST_ZERO;
      pcpMap <= `RL_RST_PCP;
      for (int i = 0; i < 4; i++) dscpMap[i] <= `RL_RST_ZERO;
    end else if (doWrite && wDec.hit && wDec.glb) begin
      if (wDec.idx == `RL_G_CTRL) gCtrl <= (gCtrl & ~wMask) | (wData & wMask);
      if (wDec.idx == `RL_G_PCP) pcpMap <= (pcpMap & ~wMask) | (wData & wMask);
      for (int i = 0; i < 4; i++) begin
        if (wDec.idx == `RL_G_DSCP0 + 3'(i)) dscpMap[i] <= (dscpMap[i] & ~wMask) | (wData & wMask);
      end
    end
  end

  // per-port register writes, separate ingress and egress settings
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int p = 0; p < NP; p++) begin
        portCtl[p] <= `RL_RST_ZERO;
        inCtl[p]   <= `RL_RST_ZERO;
        inCode[p]  <= `RL_RST_ZERO;
        egCode[p]  <= `RL_RST_ZERO;
        ratio[p]   <= `RL_RST_RATIO;
      end
    end else if (doWrite && wDec.hit && !wDec.glb) begin
      for (int p = 0; p < NP; p++) begin
        if (wDec.port == 3'(p)) begin
          case (wDec.idx)
            `RL_R_PORTCTL: portCtl[p] <= (portCtl[p] & ~wMask) | (wData & wMask);
            `RL_R_INCTL:   inCtl[p]   <= (inCtl[p] & ~wMask) | (wData & wMask);
            `RL_R_INCODE:  inCode[p]  <= (inCode[p] & ~wMask) | (wData & wMask);
            `RL_R_EGCODE:  egCode[p]  <= (egCode[p] & ~wMask) | (wData & wMask);
            `RL_R_RATIO:   ratio[p]   <= (ratio[p] & ~wMask) | (wData & wMask);
            default:       ;
          endcase
        end
      end
    end
  end

  // read data mux
  always_comb begin
    next_rdata = '0;
    if (rDec.glb) begin
      case (rDec.idx)
        `RL_G_CTRL: next_rdata = gCtrl;
        `RL_G_PCP:  next_rdata = pcpMap;
        default:    next_rdata = (rDec.idx >= `RL_G_DSCP0) ? dscpMap[2'(rDec.idx - `RL_G_DSCP0)] : '0;
      endcase
    end else if (rDec.hit) begin
      case (rDec.idx)
        `RL_R_PORTCTL: next_rdata = portCtl[rDec.port];
        `RL_R_INCTL:   next_rdata = inCtl[rDec.port];
        `RL_R_INCODE:  next_rdata = inCode[rDec.port];
        `RL_R_EGCODE:  next_rdata = egCode[rDec.port];
        `RL_R_RATIO:   next_rdata = ratio[rDec.port];
        default:       next_rdata = {23'h0, inPause[rDec.port], egOk[rDec.port], inOk[rDec.port]};
      endcase
    end
  end

  // read channel
  always_ff @(posedge clk) begin
    if (srst) begin
      rSt         <= rl_pkg::RL_R_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else begin
      case (rSt)
        rl_pkg::RL_R_IDLE: begin
          if (s_axi_arvalid) begin
            rSt         <= rl_pkg::RL_R_DATA;
            s_axi_rdata <= rDec.hit ? next_rdata : '0;
            s_axi_rresp <= rDec.hit ? 2'h0 : 2'h3;
          end
        end
        rl_pkg::RL_R_DATA: if (s_axi_rready) rSt <= rl_pkg::RL_R_IDLE;
        default: rSt <= rl_pkg::RL_R_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // refill time base
  // ----------------------------------------------------------------

  // one tick per millisecond
  always_ff @(posedge clk) begin
    if (srst) tickCnt <= '0;
    else      tickCnt <= tick ? '0 : tickCnt + 1'b1;
  end
  assign tick = tickCnt == TW'(TICK_CYC - 1);

  // ----------------------------------------------------------------
  // ingress frame classification
  // ----------------------------------------------------------------
  logic [2:0]  inPort;
  logic [1:0]  inPri;
  logic [1:0]  inQ;
  logic        inCount;
  logic [31:0] inCtlP;
  logic [31:0] pcP;
  logic [31:0] dscpW;
  logic [31:0] inBits;
  logic [15:0] inBytes;

  always_comb begin
    inPort  = inFrame.port;
    inCtlP  = inCtl[inPort];
    pcP     = portCtl[inPort];
    dscpW   = dscpMap[inFrame.dscp[5:4]];
    case (pcP[`RL_PC_PRI +: 2])
      2'h0:    inPri = pcP[`RL_PC_FPRI +: 2];
      2'h2:    inPri = dscpW[{inFrame.dscp[3:0], 1'b0} +: 2];
      default: inPri = pcpMap[{inFrame.pcp, 1'b0} +: 2];
    endcase
    case (rlTopQ(qen, pcP[`RL_PC_QM +: 2]))
      2'h0:    inQ = 2'h0;
      2'h1:    inQ = (inPri > 2'h1) ? 2'h1 : inPri;
      default: inQ = inPri;
    endcase
    case (inCtlP[`RL_IN_TSEL +: 2])
      2'h0:    inCount = 1'b1;
      2'h1:    inCount = inFrame.bc | inFrame.mc | inFrame.flood;
      2'h2:    inCount = inFrame.bc | inFrame.mc;
      default: inCount = inFrame.bc;
    endcase
    inBytes = inFrame.len + (pcP[`RL_PC_IFG] ? `RL_IFG_BYTES : 16'h0)
            + (pcP[`RL_PC_PRE] ? `RL_PRE_BYTES : 16'h0);
    inBits  = {13'h0, inBytes, 3'h0};
  end

  // egress frame cost
  logic [15:0] egBytes;
  logic [31:0] egBits;
  logic [31:0] pcE;

  always_comb begin
    pcE     = portCtl[egSent.port];
    egBytes = egSent.len + (pcE[`RL_PC_IFG] ? `RL_IFG_BYTES : 16'h0)
            + (pcE[`RL_PC_PRE] ? `RL_PRE_BYTES : 16'h0);
    egBits  = {13'h0, egBytes, 3'h0};
  end

  // ----------------------------------------------------------------
  // meters: one bit bucket and one packet bucket per queue in each direction
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NP; p++) begin : g_port
    logic [1:0] spd;
    logic [1:0] top;
    logic       fc;
    assign spd = portSpeed[2*p +: 2];
    assign top = rlTopQ(qen, portCtl[p][`RL_PC_QM +: 2]);
    assign fc  = inCtl[p][`RL_IN_FC];

    for (genvar q = 0; q < 4; q++) begin : g_q
      logic signed [33:0] iB;
      logic signed [33:0] iP;
      logic signed [33:0] eB;
      logic signed [33:0] eP;
      logic [31:0]        iRB;
      logic [31:0]        iRP;
      logic [31:0]        eRB;
      logic [31:0]        eRP;
      logic [6:0]         iC;
      logic [6:0]         eC;
      logic               lower;
      logic               iHit;
      logic               eHit;
      logic               ePps;

      assign iC    = inCode[p][8*q +: 7];
      assign eC    = egCode[p][8*top +: 7];
      assign lower = q < top;
      assign ePps  = portCtl[p][`RL_PC_EGPPS];

      // ingress rates per priority
      assign iRB = portCtl[p][`RL_PC_INPPS] ? `RL_UNL : rlRate(iC, spd, 1'b0);
      assign iRP = portCtl[p][`RL_PC_INPPS] ? rlRate(iC, spd, 1'b1) : `RL_UNL;

      // egress rates: top queue exact, lower by ratio of top
      always_comb begin
        eRB = rlRate(ePps ? rlBound(eC) : eC, spd, 1'b0);
        eRP = ePps ? rlRate(eC, spd, 1'b1) : `RL_UNL;
        if (!ePps) begin
          eRB = rlRate(lower ? eC : egCode[p][8*q +: 7], spd, 1'b0);
        end else if (!lower) begin
          eRB = rlRate(rlBound(egCode[p][8*q +: 7]), spd, 1'b0);
          eRP = rlRate(egCode[p][8*q +: 7], spd, 1'b1);
        end
        if (lower) begin
          eRB = rlScale(eRB, ratio[p][4*q +: 4]);
          eRP = rlScale(eRP, ratio[p][4*q +: 4]);
        end
      end

      assign inOk[p][q] = (iRB == `RL_UNL || iB >= 0) && (iRP == `RL_UNL || iP >= 0);
      assign egOk[p][q] = (eRB == `RL_UNL || eB >= 0) && (eRP == `RL_UNL || eP >= 0);

      // dropped frames are not charged, paused frames are still charged
      assign iHit = inFrame.valid && inPort == 3'(p) && inQ == 2'(q) && inCount
                    && (inOk[p][q] || fc);
      assign eHit = egSent.valid && egSent.port == 3'(p)
                    && (top == 2'h0 ? 2'h0 : egSent.queue) == 2'(q);

      // ingress buckets
      always_ff @(posedge clk) begin
        if (srst) begin
          iB <= '0;
          iP <= '0;
        end else begin
          iB <= rlNext(iB, iRB, tick, iHit, inBits, `RL_BURST_BITS);
          iP <= rlNext(iP, iRP, tick, iHit, `RL_PKT_COST, `RL_PKT_COST);
        end
      end

      // egress leaky buckets: debt holds the queue, stretching the gap
      always_ff @(posedge clk) begin
        if (srst) begin
          eB <= '0;
          eP <= '0;
        end else begin
          eB <= rlNext(eB, eRB, tick, eHit, egBits, `RL_BURST_BITS);
          eP <= rlNext(eP, eRP, tick, eHit, `RL_PKT_COST, `RL_PKT_COST);
        end
      end

      // per-queue transmit permission
      always_ff @(posedge clk) begin
        if (srst) egReady[4*p+q] <= 1'b0;
        else      egReady[4*p+q] <= egOk[p][top == 2'h0 ? 0 : q];
      end
    end

    // flow control while any metered priority is over its limit
    always_ff @(posedge clk) begin
      if (srst) inPause[p] <= 1'b0;
      else      inPause[p] <= fc && !(&inOk[p]);
    end

    // backlog fills queue memory; then drop or pause
    always_ff @(posedge clk) begin
      if (srst) begin
        congDrop[p]  <= 1'b0;
        congPause[p] <= 1'b0;
      end else begin
        congDrop[p]  <= memFull[p] && !fc;
        congPause[p] <= memFull[p] && fc;
      end
    end
  end

  // ----------------------------------------------------------------
  // ingress verdict
  // ----------------------------------------------------------------

  // verdict one cycle after the frame is offered
  always_ff @(posedge clk) begin
    if (srst) begin
      inDone <= 1'b0;
      inDrop <= 1'b0;
    end else begin
      inDone <= inFrame.valid;
      inDrop <= inFrame.valid && inCount && !inOk[inPort][inQ] && !inCtlP[`RL_IN_FC];
    end
  end

endmodule : rl_port_rate_limiter

// File: rl_map.svh
`ifndef RL_MAP_SVH
`define RL_MAP_SVH

// ----------------------------------------------------------------
// register map (byte addresses, 12-bit window)
// ----------------------------------------------------------------
`define RL_A_PORT0     12'h100
`define RL_PORT_SH     5
`define RL_G_CTRL      3'h0
`define RL_G_PCP       3'h1
`define RL_G_DSCP0     3'h2
`define RL_G_DSCP3     3'h5
`define RL_R_PORTCTL   3'h0
`define RL_R_INCTL     3'h1
`define RL_R_INCODE    3'h2
`define RL_R_EGCODE    3'h3
`define RL_R_RATIO     3'h4
`define RL_R_STAT      3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RL_G_QEN       3
`define RL_IN_TSEL     2
`define RL_IN_FC       4
`define RL_PC_INPPS    0
`define RL_PC_EGPPS    1
`define RL_PC_PRI      3
`define RL_PC_QM       5
`define RL_PC_IFG      7
`define RL_PC_PRE      8
`define RL_PC_FPRI     9

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RL_RST_PCP     32'h0000fa50
`define RL_RST_RATIO   32'h00008421
`define RL_RST_ZERO    32'h00000000

// ----------------------------------------------------------------
// rate table figures, per 1 ms tick (bits or milli-packets)
// ----------------------------------------------------------------
`define RL_UNL         32'hffffffff
`define RL_STEP_BPS    32'h000003e8
`define RL_STEP_PPS    32'h00000780
`define RL_FINE_BPS    32'h00000040
`define RL_LAST_BPS    32'h000003c9
`define RL_FIRST_PPS   32'h00000040
`define RL_FINE_PPS    32'h00000080
`define RL_GIG_MUL     32'h0000000a
`define RL_CODE_CRS    7'h64
`define RL_CODE_F0     7'h65
`define RL_CODE_F1     7'h73
`define RL_CAP_10M     7'h0a
`define RL_IFG_BYTES   16'h000c
`define RL_PRE_BYTES   16'h0008
`define RL_PKT_COST    32'h000003e8
`define RL_BURST_BITS  32'h00004000
`define RL_RATIO_SH    3
`define RL_TICK_NS     1000000
`define RL_CLK_NS      10

`endif

// File: rl_pkg.sv
package rl_pkg;

  typedef enum logic [1:0] {RL_SPD_10 = 2'h0, RL_SPD_100 = 2'h1, RL_SPD_1000 = 2'h2} rl_speed_t;

  typedef enum logic {RL_W_IDLE = 1'b0, RL_W_RESP = 1'b1} rl_wst_t;
  typedef enum logic {RL_R_IDLE = 1'b0, RL_R_DATA = 1'b1} rl_rst_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  port;
    logic [15:0] len;
    logic        mc;
    logic        bc;
    logic        flood;
    logic [2:0]  pcp;
    logic [5:0]  dscp;
  } rl_inframe_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  port;
    logic [1:0]  queue;
    logic [15:0] len;
  } rl_egframe_t;

  typedef struct packed {
    logic       hit;
    logic       glb;
    logic [2:0] port;
    logic [2:0] idx;
  } rl_dec_t;

endpackage : rl_pkg

// File: rl_port_rate_limiter_asserts.sv
`timescale 1ns/1ps
module rl_asserts #(
  parameter int NP = 5
) (
  input wire logic                clk,
  input wire logic                srst,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire rl_pkg::rl_inframe_t inFrame,
  input wire logic                inDone,
  input wire logic                inDrop,
  input wire logic [NP-1:0]       memFull,
  input wire logic [NP-1:0]       congDrop,
  input wire logic [NP-1:0]       congPause
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ans; inFrame.valid ##1 inDone; endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid; endsequence
  property p_done; inFrame.valid |-> s_ans; endproperty
  property p_cause; inDone |-> $past(inFrame.valid); endproperty
  property p_drop; inDrop |-> inDone; endproperty
  property p_cong; memFull[0] |=> congDrop[0] || congPause[0]; endproperty
  property p_idle; !memFull[0] |=> !congDrop[0] && !congPause[0]; endproperty
  property p_excl; !(congDrop[0] && congPause[0]); endproperty
  property p_rd; s_axi_arvalid && s_axi_arready |-> s_rd; endproperty
  property p_rcause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid); endproperty
  a_done: assert property (p_done) else $error("no frame answer");
  a_cause: assert property (p_cause) else $error("stray answer");
  a_drop: assert property (p_drop) else $error("stray drop");
  a_cong: assert property (p_cong) else $error("no congestion");
  a_idle: assert property (p_idle) else $error("stray congestion");
  a_excl: assert property (p_excl) else $error("drop and pause");
  a_rd: assert property (p_rd) else $error("no read answer");
  a_rcause: assert property (p_rcause) else $error("stray read answer");
endmodule : rl_asserts
bind rl_port_rate_limiter rl_asserts #(.NP(NP)) u_asserts (.clk, .srst, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .inFrame, .inDone, .inDrop, .memFull, .congDrop, .congPause);

// File: rl_qmgr.sv
`timescale 1ns/1ps
module rl_qmgr #(
  parameter logic [15:0] LEN = 16'h05dc
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [19:0]         egReady,
  output      rl_pkg::rl_egframe_t egSent,
  output      logic [15:0]         sent
);
  logic [2:0] gap;
  // sends queue 0 frames of port 0, idle fields toggle
  always_ff @(posedge clk) begin
    if (srst) begin
      egSent <= '0;
      gap <= 3'h0;
      sent <= 16'h0;
    end else if (gap == 3'h0 && egReady[0] === 1'b1) begin
      egSent <= '{valid:1'b1, port:3'h0, queue:2'h0, len:LEN};
      gap <= 3'h4;
      sent <= sent + 16'h1;
    end else begin
      egSent <= {1'b0, ~egSent[20:0]};
      gap <= (gap == 3'h0) ? gap : gap - 3'h1;
    end
  end
endmodule : rl_qmgr

// File: rl_port_rate_limiter_bench.sv
`timescale 1ns/1ps
`include "rl_map.svh"
module rl_port_rate_limiter_bench;
  logic                clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic                s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                s_axi_arready, s_axi_rvalid, inDone, inDrop;
  logic [11:0]         s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]         s_axi_wdata = 0, s_axi_rdata, seed = 32'hd680;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [9:0]          portSpeed = 10'h155;
  logic [4:0]          memFull = 0, inPause, congDrop, congPause;
  logic [19:0]         egReady;
  logic [15:0]         sent, base;
  rl_pkg::rl_inframe_t inFrame = '0;
  rl_pkg::rl_egframe_t egSent;
  logic                qi[$];
  logic [33:0]         qr[$];
  logic [1:0]          qb[$];
  logic [10:0]         tc[6] = '{11'h200, 11'h281, 11'h274, 11'h00b, 11'h4e5, 11'h565};
  int                  fail_count = 0, comparisons = 0, cyc = 0, i;
  rl_port_rate_limiter #(.TICK_CYC(100)) DUT (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .portSpeed, .memFull, .inFrame, .inDone, .inDrop, .inPause, .egSent, .egReady,
    .congDrop, .congPause);
  rl_qmgr PM (.clk, .srst, .egReady, .egSent, .sent);
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task summarize;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    qb.push_back(2'h0);
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    qr.push_back(e);
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
  endtask : rd
  task fr(input logic d);
    inFrame <= '{1'b1, 3'h0, {6'h1, seed[9:0]}, seed[10], seed[11], seed[12], seed[15:13], seed[21:16]};
    qi.push_back(d);
    seed = lfsr(seed);
    @(posedge clk);
  endtask : fr
  // compares answers with the oldest notes, cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (inDone === 1'b1) chk({33'h0, inDrop}, {33'h0, qi.pop_front()});
    if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, qr.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, qb.pop_front()});
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // main sequence: registers, egress pacing, ingress cases
  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    rd(12'h004, {2'h0, `RL_RST_PCP});
    rd(12'h110, {2'h0, `RL_RST_RATIO});
    rd(12'h0f0, 34'h300000000);
    repeat (1000) @(posedge clk);
    chk({33'h0, sent > 16'd100}, 34'h1);
    wr(12'h10c, 32'h65656565);
    repeat (10) @(posedge clk);
    base = sent;
    repeat (1000) @(posedge clk);
    chk({33'h0, (sent - base) < 16'd3}, 34'h1);
    wr(12'h10c, 32'h0);
    wr(12'h000, 32'h8);
    for (i = 0; i < 6; i++) begin
      portSpeed <= {8'h55, tc[i][10:9]};
      wr(12'h104, {27'h0, tc[i][8], 4'h0});
      wr(12'h108, {4{1'b0, tc[i][6:0]}});
      fr(1'b0);
      fr(tc[i][7]);
      fr(tc[i][7]);
      inFrame.valid <= 1'b0;
    end
    repeat (2) @(posedge clk);
    chk({33'h0, inPause[0]}, 34'h1);
    rd(12'h108, {2'h0, 32'h65656565});
    memFull <= 5'h1;
    repeat (4) @(posedge clk);
    chk({32'h0, congDrop[0], congPause[0]}, 34'h1);
    memFull <= 5'h0;
    repeat (4) @(posedge clk);
    chk({32'h0, congDrop[0], congPause[0]}, 34'h0);
    summarize();
  end
endmodule : rl_port_rate_limiter_bench
